// ==== common/sfcp_pkg.sv ====
// sfcp_pkg.sv: frame states and array cycle kinds
// assumes the constants header is compiled alongside
package sfcp_pkg;
  typedef enum logic [6:0] {
    SFCP_IDLE  = 7'b0000001,
    SFCP_OPC   = 7'b0000010,
    SFCP_ADDR  = 7'b0000100,
    SFCP_DUMMY = 7'b0001000,
    SFCP_DIN   = 7'b0010000,
    SFCP_DOUT  = 7'b0100000,
    SFCP_SKIP  = 7'b1000000
  } sfcp_state_e;
  typedef enum logic [2:0] {
    OPK_NONE = 3'h0, OPK_PROG = 3'h1, OPK_W4K = 3'h2, OPK_W32K = 3'h3,
    OPK_W64K = 3'h4, OPK_WALL = 3'h5, OPK_STATUS = 3'h6
  } sfcp_opk_e;
endpackage : sfcp_pkg

// ==== common/sfcp_regs.svh ====
// sfcp_regs.svh: opcodes, status fields and protect limits
// assumes inclusion by the flash command front end only
// What this block does
// - latch set opcode sets write latch
// - latch cleared by reset, clear opcode, completions
// - asleep, only wake-up opcode is obeyed
// - status byte layout lock, level, latch, busy
// - busy high during program, wipe, status write
// - no latch, no status write, program, wipe
// - level bits guard program and wipe regions
// - large variant protect limits per level code
// - small variant protect limits per level code
// - level bits change only outside hardware lock
// - whole-array wipe only with level zero
// - lock bit plus low pin freezes status
// - lock and level bits reset to zero
// - bits move in msb first on rising edges
// - read data driven until chip select rises
// - write-type frames must end on byte boundary
// - partial program byte writes nothing, keeps latch
// - read and fast read decode with address
// - program and sector wipe opcodes take three addresses
// - status read repeats, status write one byte
// - identity reads return maker, device, unique
// - sample on rising, shift on falling edges
// - dual read puts even bits on lane0
// - status write keeps bits 6,5,1,0; 6,5 zero
`ifndef SFCP_REGS_SVH
`define SFCP_REGS_SVH
`define SFCP_OP_LATCH_SET 8'h06
`define SFCP_OP_LATCH_CLR 8'h04
`define SFCP_OP_STATUS_RD 8'h05
`define SFCP_OP_STATUS_WR 8'h01
`define SFCP_OP_READ      8'h03
`define SFCP_OP_FAST      8'h0b
`define SFCP_OP_DUAL      8'h3b
`define SFCP_OP_PROG      8'h02
`define SFCP_OP_WIPE4K    8'h20
`define SFCP_OP_WIPE32K   8'h52
`define SFCP_OP_WIPE64K   8'hd8
`define SFCP_OP_WIPEALL_A 8'hc7
`define SFCP_OP_WIPEALL_B 8'h60
`define SFCP_OP_SLEEP     8'hb9
`define SFCP_OP_RESUME    8'hab
`define SFCP_OP_MAKER     8'h90
`define SFCP_OP_IDENT     8'h9f
`define SFCP_OP_UNIQUE    8'h4b
`define SFCP_ST_LOCK      7
`define SFCP_ST_LVL_HI    4
`define SFCP_ST_LVL_LO    2
`define SFCP_ST_LATCH     1
`define SFCP_ST_BUSYB     0
`define SFCP_ST_RESET     8'h00
`define SFCP_L_1M_1       24'h01dfff
`define SFCP_L_1M_2       24'h01bfff
`define SFCP_L_1M_3       24'h017fff
`define SFCP_L_1M_4       24'h00ffff
`define SFCP_L_1M_ALL     24'h01ffff
`define SFCP_L_512K_1     24'h00dfff
`define SFCP_L_512K_2     24'h00bfff
`define SFCP_L_512K_3     24'h007fff
`define SFCP_L_512K_ALL   24'h00ffff
`endif

// ==== hw/sfcp_top.sv ====
// sfcp_top.sv: serial flash command front end, protection, page fifo
// assumes spi pins asynchronous to ref_clk; array controller on ref_clk
`timescale 1ns/100ps
`include "sfcp_regs.svh"

module sfcp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr;
  logic [AW:0]      rdPtr;
  logic [AW:0]      next_wrPtr;
  logic [AW:0]      next_rdPtr;
  logic [AW:0]      fill;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two");
  end

  assign fill     = wrPtr - rdPtr;
  assign inReady  = fill != (AW+1)'(DEPTH);
  assign outValid = fill != '0;
  assign outData  = mem[rdPtr[AW-1:0]];

  always_comb begin
    next_wrPtr = wrPtr;
    next_rdPtr = rdPtr;
    if (flush) begin
      next_wrPtr = '0;
      next_rdPtr = '0;
    end else begin
      if (inValid && inReady) next_wrPtr = wrPtr + 1'b1;
      if (outValid && outReady) next_rdPtr = rdPtr + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
    end
    if (inValid && inReady && !flush) mem[wrPtr[AW-1:0]] <= inData;
  end
endmodule : sfcp_fifo

module sfcp_top #(
  parameter bit           DENSITY_1M = 1'b1,
  parameter int           FIFO_DEPTH = 32,
  parameter logic [7:0]   MAKER_ID   = 8'h5a,    // arbitrary value
  parameter logic [15:0]  DEV_ID     = 16'h1234, // arbitrary value
  parameter logic [7:0]   SHORT_ID   = 8'h21,    // arbitrary value
  parameter logic [127:0] UNIQUE_ID  = 128'h0123456789abcdef0f1e2d3c4b5a6978
) (
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  input  wire logic                spiClk,
  input  wire logic                spiCsN,
  input  wire logic                wpN,
  input  wire logic                dual_lane0In,
  output logic                     dual_lane0Out,
  output logic                     dual_lane0Oe,
  output logic                     dual_lane1Out,
  output logic                     dual_lane1Oe,
  output logic [23:0]              arrayAddr,
  input  wire logic [7:0]          arrayRdData,
  output logic                     opStart,
  output sfcp_pkg::sfcp_opk_e      opKind,
  output logic                     progValid,
  input  wire logic                progReady,
  output logic [7:0]               progData,
  input  wire logic                cycleDone,
  output logic [7:0]               statusReg
);
  import sfcp_pkg::*;

  if (FIFO_DEPTH < 2) begin : g_bad_fifo
    $error("page fifo too shallow");
  end

  // ****************************************************
  // pin synchronisers
  // ****************************************************
  logic [2:0] csS;
  logic [2:0] ckS;
  logic [1:0] diS;
  logic [1:0] wpS;
  logic       ckRise;
  logic       ckFall;
  logic       csLow;
  logic       csRise;
  logic       hwLock;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      csS <= 3'h7;
      ckS <= 3'h0;
      diS <= 2'h0;
      wpS <= 2'h3;
    end else begin
      csS <= {csS[1:0], spiCsN};
      ckS <= {ckS[1:0], spiClk};
      diS <= {diS[0], dual_lane0In};
      wpS <= {wpS[0], wpN};
    end
  end

  assign ckRise = ckS[1] & ~ckS[2];
  assign ckFall = ~ckS[1] & ckS[2];
  assign csLow  = ~csS[1];
  assign csRise = csS[1] & ~csS[2];

  // ****************************************************
  // frame state and status
  // ****************************************************
  sfcp_state_e state;
  sfcp_state_e next_state;
  sfcp_state_e curState;
  sfcp_opk_e   next_opKind;
  logic [7:0]  opcode,  next_opcode;
  logic [7:0]  shiftIn, next_shiftIn;
  logic [2:0]  bitPos,  next_bitPos;
  logic [1:0]  byteCnt, next_byteCnt;
  logic [1:0]  dataCnt, next_dataCnt;
  logic [3:0]  outCnt,  next_outCnt;
  logic [2:0]  outIdx,  next_outIdx;
  logic [7:0]  outByte, next_outByte;
  logic [7:0]  wrByte,  next_wrByte;
  logic [23:0] addr,    next_addr;
  logic [2:0]  level,   next_level;
  logic        status_lock_bit,     next_srp;
  logic        write_latch_flag,     next_wel;
  logic        busy,    next_busy;
  logic        sleeping, next_sleeping;
  logic        commit,  next_commit;
  logic        next_opStart;
  logic        next_lane0Out, next_lane1Out;
  logic        next_lane0Oe,  next_lane1Oe;
  logic [7:0]  byteIn;
  logic [7:0]  srcByte;
  logic [7:0]  curByte;
  logic [7:0]  statusNow;
  logic        lastBit;
  logic        push;
  logic        flush;
  logic        fifoInReady;
  logic        fifoOutValid;
  logic        frameEnd;
  logic        execPoint;

  function automatic logic prot_hit(input logic [2:0]  lv,
                                    input logic [23:0] a);
    logic [23:0] lim;
    lim = `SFCP_L_1M_ALL;
    if (DENSITY_1M) begin
      case (lv)
        3'b001:  lim = `SFCP_L_1M_1;
        3'b010:  lim = `SFCP_L_1M_2;
        3'b011:  lim = `SFCP_L_1M_3;
        3'b100:  lim = `SFCP_L_1M_4;
        default: lim = `SFCP_L_1M_ALL;
      endcase
    end else begin
      case (lv)
        3'b001:  lim = `SFCP_L_512K_1;
        3'b010:  lim = `SFCP_L_512K_2;
        3'b011:  lim = `SFCP_L_512K_3;
        default: lim = `SFCP_L_512K_ALL;
      endcase
    end
    prot_hit = (lv != 3'b000) && (a <= lim);
  endfunction : prot_hit

  function automatic sfcp_opk_e wipe_kind(input logic [7:0] op);
    case (op)
      `SFCP_OP_WIPE4K:  wipe_kind = OPK_W4K;
      `SFCP_OP_WIPE32K: wipe_kind = OPK_W32K;
      default:          wipe_kind = OPK_W64K;
    endcase
  endfunction : wipe_kind

  assign hwLock    = status_lock_bit & ~wpS[1];
  assign curState  = (state == SFCP_IDLE && csLow) ? SFCP_OPC : state;
  assign byteIn    = {shiftIn[6:0], diS[1]};
  assign frameEnd  = csRise && state != SFCP_IDLE;
  assign execPoint = frameEnd && state == SFCP_DIN && bitPos == 3'd0;
  assign statusReg = statusNow;
  assign arrayAddr = addr;

  always_comb begin
    statusNow = `SFCP_ST_RESET;
    statusNow[`SFCP_ST_LOCK] = status_lock_bit;
    statusNow[`SFCP_ST_LVL_HI:`SFCP_ST_LVL_LO] = level;
    statusNow[`SFCP_ST_LATCH] = write_latch_flag;
    statusNow[`SFCP_ST_BUSYB] = busy;
  end

  always_comb begin
    case (opcode)
      `SFCP_OP_STATUS_RD: srcByte = statusNow;
      `SFCP_OP_RESUME:    srcByte = SHORT_ID;
      `SFCP_OP_MAKER:     srcByte = outCnt[0] ? SHORT_ID : MAKER_ID;
      `SFCP_OP_IDENT: begin
        case (outCnt)
          4'd0:    srcByte = MAKER_ID;
          4'd1:    srcByte = DEV_ID[15:8];
          default: srcByte = DEV_ID[7:0];
        endcase
      end
      `SFCP_OP_UNIQUE:    srcByte = UNIQUE_ID[{~outCnt, 3'b000} +: 8];
      default:            srcByte = arrayRdData;
    endcase
  end

  always_comb begin
    next_state    = curState;
    next_opcode   = opcode;
    next_shiftIn  = shiftIn;
    next_bitPos   = bitPos;
    next_byteCnt  = byteCnt;
    next_dataCnt  = dataCnt;
    next_outCnt   = outCnt;
    next_outIdx   = outIdx;
    next_outByte  = outByte;
    next_wrByte   = wrByte;
    next_addr     = addr;
    next_level    = level;
    next_srp      = status_lock_bit;
    next_wel      = write_latch_flag;
    next_busy     = busy;
    next_sleeping = sleeping;
    next_commit   = commit;
    next_opStart  = 1'b0;
    next_opKind   = opKind;
    next_lane0Out = dual_lane0Out;
    next_lane1Out = dual_lane1Out;
    curByte       = outByte;
    lastBit       = 1'b0;
    push          = 1'b0;
    flush         = 1'b0;
    if (cycleDone && busy) begin
      next_busy   = 1'b0;
      next_wel    = 1'b0;
      next_commit = 1'b0;
    end
    if (frameEnd) begin
      next_state   = SFCP_IDLE;
      next_bitPos  = 3'd0;
      next_byteCnt = 2'd0;
      next_dataCnt = 2'd0;
      next_outCnt  = 4'd0;
      next_outIdx  = 3'd7;
      if (opcode == `SFCP_OP_RESUME &&
          (state == SFCP_DUMMY || state == SFCP_DOUT))
        next_sleeping = 1'b0;
      if (execPoint) begin
        case (opcode)
          `SFCP_OP_LATCH_SET: if (dataCnt == 2'd0) next_wel = 1'b1;
          `SFCP_OP_LATCH_CLR: if (dataCnt == 2'd0) next_wel = 1'b0;
          `SFCP_OP_SLEEP: if (dataCnt == 2'd0) next_sleeping = 1'b1;
          `SFCP_OP_STATUS_WR: begin
            if (dataCnt == 2'd1 && write_latch_flag && !hwLock) begin
              next_srp     = next_wrByte[`SFCP_ST_LOCK];
              next_level   = wrByte[`SFCP_ST_LVL_HI:`SFCP_ST_LVL_LO];
              next_busy    = 1'b1;
              next_opStart = 1'b1;
              next_opKind  = OPK_STATUS;
            end
          end
          `SFCP_OP_PROG: begin
            if (dataCnt != 2'd0 && write_latch_flag && !prot_hit(level, addr)) begin
              next_commit  = 1'b1;
              next_busy    = 1'b1;
              next_opStart = 1'b1;
              next_opKind  = OPK_PROG;
            end
          end
          `SFCP_OP_WIPE4K, `SFCP_OP_WIPE32K, `SFCP_OP_WIPE64K: begin
            if (dataCnt == 2'd0 && write_latch_flag && !prot_hit(level, addr)) begin
              next_busy    = 1'b1;
              next_opStart = 1'b1;
              next_opKind  = wipe_kind(opcode);
            end
          end
          `SFCP_OP_WIPEALL_A, `SFCP_OP_WIPEALL_B: begin
            if (dataCnt == 2'd0 && write_latch_flag && level == 3'b000) begin
              next_busy    = 1'b1;
              next_opStart = 1'b1;
              next_opKind  = OPK_WALL;
            end
          end
          default: ;
        endcase
      end
      if (opcode == `SFCP_OP_PROG && !next_commit) flush = 1'b1;
    end else if (ckRise && csLow) begin
      next_shiftIn = byteIn;
      next_bitPos  = bitPos + 3'd1;
      if (bitPos == 3'd7) begin
        case (curState)
          SFCP_OPC: begin
            next_opcode = byteIn;
            next_state  = SFCP_SKIP;
            if (sleeping) begin
              if (byteIn == `SFCP_OP_RESUME) next_state = SFCP_DUMMY;
            end else if (!busy || byteIn == `SFCP_OP_STATUS_RD) begin
              case (byteIn)
                `SFCP_OP_STATUS_RD, `SFCP_OP_IDENT: next_state = SFCP_DOUT;
                `SFCP_OP_READ, `SFCP_OP_FAST, `SFCP_OP_DUAL, `SFCP_OP_PROG,
                `SFCP_OP_WIPE4K, `SFCP_OP_WIPE32K, `SFCP_OP_WIPE64K,
                `SFCP_OP_MAKER, `SFCP_OP_UNIQUE: next_state = SFCP_ADDR;
                `SFCP_OP_STATUS_WR, `SFCP_OP_LATCH_SET, `SFCP_OP_LATCH_CLR,
                `SFCP_OP_SLEEP, `SFCP_OP_WIPEALL_A,
                `SFCP_OP_WIPEALL_B: next_state = SFCP_DIN;
                `SFCP_OP_RESUME: next_state = SFCP_DUMMY;
                default: next_state = SFCP_SKIP;
              endcase
            end
          end
          SFCP_ADDR: begin
            next_addr    = {addr[15:0], byteIn};
            next_byteCnt = byteCnt + 2'd1;
            if (byteCnt == 2'd2) begin
              next_byteCnt = 2'd0;
              case (opcode)
                `SFCP_OP_READ, `SFCP_OP_MAKER: next_state = SFCP_DOUT;
                `SFCP_OP_FAST, `SFCP_OP_DUAL,
                `SFCP_OP_UNIQUE: next_state = SFCP_DUMMY;
                default: next_state = SFCP_DIN;
              endcase
            end
          end
          SFCP_DUMMY: begin
            next_byteCnt = byteCnt + 2'd1;
            if (opcode != `SFCP_OP_RESUME || byteCnt == 2'd2) begin
              next_byteCnt = 2'd0;
              next_state   = SFCP_DOUT;
            end
          end
          SFCP_DIN: begin
            if (dataCnt != 2'd3) next_dataCnt = dataCnt + 2'd1;
            if (dataCnt == 2'd0) next_wrByte = byteIn;
            push = (opcode == `SFCP_OP_PROG);
          end
          default: ;
        endcase
      end
    end else if (ckFall && state == SFCP_DOUT) begin
      curByte       = (outIdx == 3'd7) ? srcByte : outByte;
      next_outByte  = curByte;
      next_lane1Out = curByte[outIdx];
      if (opcode == `SFCP_OP_DUAL) begin
        next_lane0Out = curByte[outIdx - 3'd1];
        lastBit       = (outIdx == 3'd1);
        next_outIdx   = outIdx - 3'd2;
      end else begin
        lastBit       = (outIdx == 3'd0);
        next_outIdx   = outIdx - 3'd1;
      end
      if (lastBit) begin
        next_outIdx = 3'd7;
        next_addr   = addr + 24'd1;
        if (opcode == `SFCP_OP_IDENT && outCnt == 4'd2) next_outCnt = 4'd0;
        else next_outCnt = outCnt + 4'd1;
      end
    end
    next_lane1Oe = (next_state == SFCP_DOUT);
    next_lane0Oe = next_lane1Oe && next_opcode == `SFCP_OP_DUAL;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state         <= SFCP_IDLE;
      opcode        <= 8'h00;
      shiftIn       <= 8'h00;
      bitPos        <= 3'h0;
      byteCnt       <= 2'h0;
      dataCnt       <= 2'h0;
      outCnt        <= 4'h0;
      outIdx        <= 3'h7;
      outByte       <= 8'h00;
      wrByte        <= 8'h00;
      addr          <= 24'h000000;
      level         <= 3'h0;
      status_lock_bit           <= 1'b0;
      write_latch_flag           <= 1'b0;
      busy          <= 1'b0;
      sleeping      <= 1'b0;
      commit        <= 1'b0;
      opStart       <= 1'b0;
      opKind        <= OPK_NONE;
      dual_lane0Out <= 1'b0;
      dual_lane1Out <= 1'b0;
      dual_lane0Oe  <= 1'b0;
      dual_lane1Oe  <= 1'b0;
    end else begin
      state         <= next_state;
      opcode        <= next_opcode;
      shiftIn       <= next_shiftIn;
      bitPos        <= next_bitPos;
      byteCnt       <= next_byteCnt;
      dataCnt       <= next_dataCnt;
      outCnt        <= next_outCnt;
      outIdx        <= next_outIdx;
      outByte       <= next_outByte;
      wrByte        <= next_wrByte;
      addr          <= next_addr;
      level         <= next_level;
      status_lock_bit           <= next_srp;
      write_latch_flag           <= next_wel;
      busy          <= next_busy;
      sleeping      <= next_sleeping;
      commit        <= next_commit;
      opStart       <= next_opStart;
      opKind        <= next_opKind;
      dual_lane0Out <= next_lane0Out;
      dual_lane1Out <= next_lane1Out;
      dual_lane0Oe  <= next_lane0Oe;
      dual_lane1Oe  <= next_lane1Oe;
    end
  end

  // ****************************************************
  // page data buffer
  // ****************************************************
  sfcp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_page_fifo (
    .clk      (ref_clk),
    .rst_n    (rst_n),
    .flush    (flush),
    .inValid  (push),
    .inReady  (fifoInReady),
    .inData   (byteIn),
    .outValid (fifoOutValid),
    .outReady (progReady && commit),
    .outData  (progData)
  );
  assign progValid = fifoOutValid && commit;

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_latch_set: assert property (execPoint && opcode == `SFCP_OP_LATCH_SET
    && dataCnt == 2'd0 |=> write_latch_flag) else $error("latch not set");
  a_latch_clear: assert property ((cycleDone && busy) || (execPoint
    && opcode == `SFCP_OP_LATCH_CLR && dataCnt == 2'd0) |=> !write_latch_flag)
    else $error("latch not cleared");
  a_sleep_ignore: assert property (sleeping && ckRise && csLow
    && !frameEnd && curState == SFCP_OPC && bitPos == 3'd7
    && byteIn != `SFCP_OP_RESUME |=> state == SFCP_SKIP)
    else $error("opcode obeyed while asleep");
  a_busy_start: assert property (opStart |-> busy && !$past(busy))
    else $error("busy not raised at cycle start");
  a_refuse_unlatched: assert property (execPoint && !write_latch_flag |=> !opStart)
    else $error("cycle started without latch");
  a_prot_block: assert property (opStart && (opKind == OPK_PROG
    || opKind == OPK_W4K || opKind == OPK_W32K || opKind == OPK_W64K)
    |-> !prot_hit(level, addr)) else $error("protected region hit");
  a_lock_freeze: assert property (hwLock && !$past(hwLock)
    |=> ($stable(status_lock_bit) && $stable(level)) [*2])
    else $error("locked status changed");
  a_wipe_gate: assert property (opStart && opKind == OPK_WALL
    |-> level == 3'b000) else $error("array wipe while protected");
  a_byte_bound: assert property (opStart |-> $past(bitPos) == 3'd0)
    else $error("cycle from partial byte");
  a_part_byte: assert property (frameEnd && state == SFCP_DIN && write_latch_flag
    && opcode == `SFCP_OP_PROG && bitPos != 3'd0 |=> write_latch_flag && !opStart
    && !progValid) else $error("partial program acted");
  a_status_keep: assert property (execPoint && dataCnt == 2'd1 && write_latch_flag
    && !hwLock && opcode == `SFCP_OP_STATUS_WR
    |=> write_latch_flag && busy && statusReg[6:5] == 2'b00)
    else $error("status write disturbed fixed bits");

  c_status_read: cover property (state == SFCP_DOUT
    && opcode == `SFCP_OP_STATUS_RD && ckFall);
  c_prog_start: cover property (opStart && opKind == OPK_PROG);
  c_sleep: cover property (sleeping ##1 !sleeping);
  c_dual_read: cover property (dual_lane0Oe && ckFall);
endmodule : sfcp_top

// ==== verif/sfcp_host.sv ====
// sfcp_host.sv: host spi controller model, mode 0, clock idle low
// assumes frames are requested one at a time by the bench
`timescale 1ns/100ps
module sfcp_host (
  output logic      spiClk,
  output logic      spiCsN,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic io0
);
  // ********************
  // frame shifting
  // ********************
  logic dual = 1'b0;
  initial begin
    spiClk = 1'b0;
    spiCsN = 1'b1;
    mosi   = 1'b0;
  end
  task automatic frame(input logic [47:0] d, input int n,
                       output logic [15:0] rx);
    rx = 16'h0;
    #10; // step off the sampling edge
    spiCsN = 1'b0;
    #200;
    for (int i = 0; i < n; i++) begin
      mosi = d[47-i];
      #200 spiClk = 1'b1;
      #100 rx = dual ? {rx[13:0], miso, io0} : {rx[14:0], miso};
      #100 spiClk = 1'b0;
    end
    #200 spiCsN = 1'b1;
    mosi = ~mosi;
    #1200;
  endtask : frame
endmodule : sfcp_host

// ==== verif/sfcp_top_tb.sv ====
// sfcp_top_tb.sv: row-driven bench for the command front end
// assumes a host model on the link and an array emulator here
`timescale 1ns/100ps
module sfcp_top_tb;
  import sfcp_pkg::*;
  typedef struct {
    logic [31:0] d;
    int          n;
    logic        wp;
    logic [7:0]  st;
    logic [31:0] ns;
  } sfcp_row_s;
  logic ref_clk = 1'b0, rst_n = 1'b0, wpN = 1'b1, cycleDone = 1'b0;
  localparam logic [7:0]  ID_MAKER = 8'h5a;    // arbitrary value
  localparam logic [15:0] ID_DEV   = 16'h1234; // arbitrary value
  localparam logic [7:0]  ID_SHORT = 8'h21;    // arbitrary value
  logic spiClk, spiCsN, mosi, miso, opStart, progValid;
  logic lane0Out, lane0Oe, lane1Out, lane1Oe, io0;
  logic [23:0] arrayAddr;
  logic [7:0] progData, statusReg, lastByte;
  logic [31:0] starts;
  logic [3:0] pend;
  logic [15:0] rx;
  sfcp_opk_e opKind, lastKind;
  int errors = 0, total_checks = 0;
  sfcp_row_s rows [17] = '{
    '{32'h06000000, 8, 1'b1, 8'h02, 0},
    '{32'h04000000, 8, 1'b1, 8'h00, 0},
    '{32'h06000000, 9, 1'b1, 8'h00, 0},
    '{32'h20000000, 32, 1'b1, 8'h00, 0},
    '{32'h06000000, 8, 1'b1, 8'h02, 0},
    '{32'h2001f000, 32, 1'b1, 8'h00, 1},
    '{32'h06000000, 8, 1'b1, 8'h02, 1},
    '{32'h01fc0000, 16, 1'b1, 8'h9c, 2},
    '{32'h06000000, 8, 1'b1, 8'h9e, 2},
    '{32'h2001f000, 32, 1'b1, 8'h9e, 2},
    '{32'hc7000000, 8, 1'b1, 8'h9e, 2},
    '{32'h01000000, 16, 1'b0, 8'h9e, 2},
    '{32'h01080000, 16, 1'b1, 8'h08, 3},
    '{32'h06000000, 8, 1'b1, 8'h0a, 3},
    '{32'hb9000000, 8, 1'b1, 8'h0a, 3},
    '{32'h04000000, 8, 1'b1, 8'h0a, 3},
    '{32'hab000000, 8, 1'b1, 8'h0a, 3}
  };
  // ********************
  // clock, parts
  // ********************
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  sfcp_host host (.spiClk(spiClk), .spiCsN(spiCsN), .mosi(mosi),
                  .miso(miso), .io0(io0));
  // released lane1 reads inverted and released lane0 reads mosi, so undriven data cannot pass
  assign miso = lane1Oe ? lane1Out : ~lane1Out;
  assign io0  = lane0Oe ? lane0Out : mosi;
  sfcp_top #(.MAKER_ID(ID_MAKER), .DEV_ID(ID_DEV), .SHORT_ID(ID_SHORT))
    dut (.ref_clk(ref_clk), .rst_n(rst_n), .spiClk(spiClk),
    .spiCsN(spiCsN), .wpN(wpN), .dual_lane0In(mosi),
    .dual_lane0Out(lane0Out), .dual_lane0Oe(lane0Oe),
    .dual_lane1Out(lane1Out), .dual_lane1Oe(lane1Oe),
    .arrayAddr(arrayAddr),
    .arrayRdData(arrayAddr[7:0]), .opStart(opStart), .opKind(opKind),
    .progValid(progValid), .progReady(1'b1), .progData(progData),
    .cycleDone(cycleDone), .statusReg(statusReg));
  // array emulator: finish each cycle 6 clocks after it starts
  always @(posedge ref_clk) begin
    cycleDone <= 1'b0;
    if (!rst_n) begin
      pend <= 4'h0;
      starts <= 0;
      lastKind <= OPK_NONE;
      lastByte <= 8'h00;
    end else if (opStart) begin
      starts <= starts + 1;
      lastKind <= opKind;
      pend <= 4'h6;
    end else if (pend != 4'h0) begin
      pend <= pend - 4'h1;
      cycleDone <= (pend == 4'h1);
    end
    if (progValid) lastByte <= progData;
  end
  // ********************
  // checking tasks
  // ********************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task automatic settle();
    int k;
    for (k = 0; k < 200 && statusReg[0] !== 1'b0; k++) @(posedge ref_clk);
    if (k == 200) begin
      errors++;
    end
    repeat (2) @(posedge ref_clk);
  endtask : settle
  task automatic send(input logic [47:0] d, input int n);
    @(posedge ref_clk);
    host.frame(d, n, rx);
  endtask : send
  // ********************
  // main sequence
  // ********************
  initial begin
    repeat (8) @(posedge ref_clk);
    check(statusReg, 8'h00);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    for (int i = 0; i < 17; i++) begin
      @(posedge ref_clk) wpN <= rows[i].wp;
      send({rows[i].d, 16'h0}, rows[i].n);
      settle();
      check(statusReg, rows[i].st);
      check(starts, rows[i].ns);
    end
    check(lastKind, OPK_STATUS);
    send(48'h04 << 40, 8);
    settle();
    check(statusReg, 8'h08);
    send(48'h05 << 40, 24);
    check(rx, 16'h0808);
    send({8'h03, 24'h000010, 16'h0}, 40);
    check(rx[7:0], 8'h10);
    send({8'h0b, 24'h000020, 16'h0}, 48);
    check(rx[7:0], 8'h20);
    host.dual = 1'b1;
    send({8'h3b, 24'h000012, 16'h0}, 48);
    host.dual = 1'b0;
    check(rx, 16'h1213);
    send(48'h9f << 40, 32);
    check(rx, ID_DEV);
    send(48'h90 << 40, 48);
    check(rx, {ID_MAKER, ID_SHORT});
    send(48'hab << 40, 40);
    check(rx[7:0], ID_SHORT);
    send(48'h06 << 40, 8);
    send({8'h02, 24'h01c000, 8'ha5, 8'h0}, 40);
    settle();
    check(starts, 4);
    check(lastKind, OPK_PROG);
    check(lastByte, 8'ha5);
    check(statusReg, 8'h08);
    send(48'h06 << 40, 8);
    send({8'h02, 24'h01c000, 8'h5c, 8'h0}, 44);
    settle();
    check(statusReg, 8'h0a);
    check(starts, 4);
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check(statusReg, 8'h00);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    send(48'h06 << 40, 8);
    check(statusReg, 8'h02);
    stop_test();
  end
endmodule : sfcp_top_tb
